// [ueth_pkg.sv]
// Purpose: shared constants and types of the endpoint transaction handler
// Assumes: one endpoint, 32-bit APB register access
// Notes:   byte offsets are multiples of four
package ueth_pkg;
  // ==========================================================
  // register offsets
  localparam logic [11:0] OFF_CSR = 12'h000;
  localparam logic [11:0] OFF_FDR = 12'h004;
  localparam logic [11:0] OFF_IEN = 12'h008;
  // ==========================================================
  // control/status word layout
  localparam int unsigned B_TXC  = 0;  // tx complete, w1c
  localparam int unsigned B_RXF  = 1;  // rx bank0 full, w1c
  localparam int unsigned B_SET  = 2;  // setup received, w1c
  localparam int unsigned B_TXR  = 4;  // tx packet ready, w1 sets
  localparam int unsigned B_DUAL = 7;  // ping-pong enable
  localparam int unsigned CNT_LSB = 16; // rx byte count field
  // ==========================================================
  // sizes and reset values
  localparam int unsigned EP_SIZE = 64;
  localparam logic [6:0]  EP_FULL = 7'h40;
  localparam logic [2:0]  IEN_RST = 3'h0;
  localparam logic        DUAL_RST = 1'b0;
  // ==========================================================
  // all registered state of the handler except the fifo memories
  typedef struct packed {
    logic             pready;
    logic             pslverr;
    logic [31:0]      prdata;
    logic             tx_complete_flag;
    logic             rxFull;
    logic             setupRcv;
    logic             dual;
    logic [2:0]       ien;
    logic [1:0]       txRdy;
    logic             fwBank;
    logic             usbBank;
    logic [1:0][6:0]  txCnt;
    logic             sending;
    logic             waitAck;
    logic [6:0]       idx;
    logic [6:0]       rxCnt;
    logic [6:0]       rdPtr;
    logic             rxBusy;
    logic             rxDrop;
    logic             setup_received_flag;
    logic             hsAck;
    logic             hsNak;
    logic             txValid;
    logic             txDone;
    logic [7:0]       txData;
    logic             irq;
  } ueth_state_t;
endpackage : ueth_pkg

// [ueth_endpoint.sv]
// Purpose: one USB full-speed endpoint: setup, data IN, data OUT
// Assumes: serial engine events are single-cycle pulses on clk
// Notes:   ping-pong applies to IN only; OUT is single bank
//
// Summary of operation
// - setup packet is acked by hardware and sets setup received flag
// - interrupt pending while setup flag set, gated by its interrupt enable bit
// - control and setup only on single-bank endpoints
// - isochronous traffic only on ping-pong endpoints
// - control runs setup, optional data, then opposite status
// - host ack of IN packet sets tx complete, frees bank, irq pending
// - ping-pong: bank 1 fillable once bank 0 marked ready
// - IN request with no ready bank gets NAK
// - OUT gets NAK while firmware owns fifo, else stored and acked
// - stored OUT sets bank0 full flag, irq pending while set
// - byte count field shows received bytes still in fifo
// - new OUT accepted only after firmware clears receive flag
`timescale 1ns/1ps
module ueth_endpoint (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        tokSetup,
  input  wire logic        tokOut,
  input  wire logic        tokIn,
  input  wire logic        rxValid,
  input  wire logic [7:0]  rxData,
  input  wire logic        rxEnd,
  input  wire logic        hostAck,
  output logic             hsAck,
  output logic             hsNak,
  output logic             txValid,
  output logic [7:0]       txData,
  output logic             txDone,
  output logic             irq
);
  // ==========================================================
  // state and memories
  ueth_pkg::ueth_state_t s;
  ueth_pkg::ueth_state_t next_s;
  logic [7:0] txMem [2][ueth_pkg::EP_SIZE];
  logic [7:0] rxMem [ueth_pkg::EP_SIZE];
  logic        acc;
  logic        wrCsr;
  logic        wrFdr;
  logic        rdFdr;
  logic        wrIen;
  logic        txPush;
  logic        rxPush;
  logic [31:0] csrView;
  logic [6:0]  heldCnt;

  // apb transfer completes at the access edge with pready high
  assign acc   = psel & penable & s.pready;
  assign wrCsr = acc & pwrite & (paddr == ueth_pkg::OFF_CSR);
  assign wrFdr = acc & pwrite & (paddr == ueth_pkg::OFF_FDR);
  assign rdFdr = acc & ~pwrite & (paddr == ueth_pkg::OFF_FDR);
  assign wrIen = acc & pwrite & (paddr == ueth_pkg::OFF_IEN);
  // bytes written while the bank is owned by usb are dropped
  assign txPush = wrFdr & ~s.txRdy[s.fwBank] &
                  (s.txCnt[s.fwBank] != ueth_pkg::EP_FULL);
  assign rxPush = rxValid & s.rxBusy & ~s.rxDrop &
                  (s.rxCnt != ueth_pkg::EP_FULL);
  assign heldCnt = 7'(s.rxCnt - s.rdPtr);

  // read view of the control/status word
  always_comb begin
    csrView = 32'h0000_0000;
    csrView[ueth_pkg::B_TXC]  = s.tx_complete_flag;
    csrView[ueth_pkg::B_RXF]  = s.rxFull;
    csrView[ueth_pkg::B_SET]  = s.setupRcv;
    // firmware sees the bank it fills next, so bank 1 looks free
    // as soon as bank 0 is handed over
    csrView[ueth_pkg::B_TXR]  = s.txRdy[s.fwBank];
    csrView[ueth_pkg::B_DUAL] = s.dual;
    csrView[ueth_pkg::CNT_LSB +: 7] = heldCnt;
  end

  // ==========================================================
  // next state
  always_comb begin
    next_s = s;
    next_s.hsAck   = 1'b0;
    next_s.hsNak   = 1'b0;
    next_s.txValid = 1'b0;
    next_s.txDone  = 1'b0;
    // apb: answer one cycle after setup, registered data
    next_s.pready  = psel & ~penable & ~s.pready;
    next_s.pslverr = 1'b0;
    next_s.prdata  = 32'h0000_0000;
    if (psel & ~penable & ~s.pready) begin
      case (paddr)
        ueth_pkg::OFF_CSR: next_s.prdata = csrView;
        ueth_pkg::OFF_FDR: next_s.prdata = {24'h00_0000,
                                            rxMem[s.rdPtr[5:0]]};
        ueth_pkg::OFF_IEN: next_s.prdata = {29'h0000_0000, s.ien};
        default:           next_s.pslverr = 1'b1;
      endcase
    end
    // firmware clears flags first so hardware sets win below
    if (wrCsr) begin
      if (pwdata[ueth_pkg::B_TXC]) next_s.tx_complete_flag = 1'b0;
      if (pwdata[ueth_pkg::B_RXF]) next_s.rxFull = 1'b0;
      if (pwdata[ueth_pkg::B_SET]) next_s.setupRcv = 1'b0;
      next_s.dual = pwdata[ueth_pkg::B_DUAL];
      if (pwdata[ueth_pkg::B_TXR] & ~s.txRdy[s.fwBank]) begin
        next_s.txRdy[s.fwBank] = 1'b1;
        // ping-pong hands the filled bank over and moves on
        if (s.dual) begin
          next_s.fwBank = ~s.fwBank;
        end
      end
    end
    if (wrIen) next_s.ien = pwdata[2:0];
    if (txPush) begin
      next_s.txCnt[s.fwBank] = 7'(s.txCnt[s.fwBank] + 7'h01);
    end
    if (rdFdr && s.rdPtr != s.rxCnt) begin
      next_s.rdPtr = 7'(s.rdPtr + 7'h01);
    end

    // ---- IN side: stream the ready bank, NAK when none
    if (s.sending) begin
      if (s.idx == s.txCnt[s.usbBank]) begin
        next_s.sending = 1'b0;
        next_s.waitAck = 1'b1;
        next_s.txDone  = 1'b1;
      end else begin
        next_s.txValid = 1'b1;
        next_s.txData  = txMem[s.usbBank][s.idx[5:0]];
        next_s.idx     = 7'(s.idx + 7'h01);
      end
    end else if (tokIn) begin
      if (s.txRdy[s.usbBank]) begin
        // a repeated token without ack resends the same bank
        next_s.sending = 1'b1;
        next_s.waitAck = 1'b0;
        next_s.idx     = 7'h00;
      end else begin
        next_s.hsNak = 1'b1;
      end
    end else if (hostAck && s.waitAck) begin
      next_s.waitAck = 1'b0;
      next_s.txRdy[s.usbBank] = 1'b0;
      next_s.txCnt[s.usbBank] = 7'h00;
      next_s.tx_complete_flag = 1'b1;
      // isochronous streams alternate banks here
      if (s.dual) next_s.usbBank = ~s.usbBank;
    end

    // ---- OUT and SETUP side
    // setup only on single-bank endpoints; otherwise ignored
    if (tokSetup && !s.dual) begin
      next_s.rxBusy  = 1'b1;
      next_s.rxDrop  = 1'b0;
      next_s.setup_received_flag = 1'b1;
      next_s.rxCnt   = 7'h00;
      next_s.rdPtr   = 7'h00;
      // a new control transfer drops any stale IN payload
      next_s.txRdy   = 2'b00;
      next_s.txCnt   = '0;
      next_s.sending = 1'b0;
      next_s.waitAck = 1'b0;
      next_s.fwBank  = 1'b0;
      next_s.usbBank = 1'b0;
    end else if (tokOut) begin
      next_s.rxBusy  = 1'b1;
      next_s.setup_received_flag = 1'b0;
      // firmware still owns the fifo: refuse and keep old bytes
      next_s.rxDrop  = s.rxFull | s.setupRcv;
      if (!(s.rxFull | s.setupRcv)) begin
        next_s.rxCnt = 7'h00;
        next_s.rdPtr = 7'h00;
      end
    end else if (rxPush) begin
      next_s.rxCnt = 7'(s.rxCnt + 7'h01);
    end
    if (rxEnd && s.rxBusy) begin
      next_s.rxBusy = 1'b0;
      if (s.rxDrop) begin
        next_s.hsNak = 1'b1;
      end else begin
        next_s.hsAck = 1'b1;
        if (s.setup_received_flag) next_s.setupRcv = 1'b1;
        else           next_s.rxFull   = 1'b1;
      end
    end

    // one level interrupt from the enabled pending flags
    next_s.irq = |({next_s.setupRcv, next_s.rxFull, next_s.tx_complete_flag}
                   & next_s.ien);
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk) begin
    if (rst) begin
      s        <= '0;
      s.dual   <= ueth_pkg::DUAL_RST;
      s.ien    <= ueth_pkg::IEN_RST;
    end else begin
      s <= next_s;
    end
  end

  // fifo storage; contents need no reset
  always_ff @(posedge clk) begin
    if (txPush) begin
      txMem[s.fwBank][s.txCnt[s.fwBank][5:0]] <= pwdata[7:0];
    end
    if (rxPush) begin
      rxMem[s.rxCnt[5:0]] <= rxData;
    end
  end

  assign prdata  = s.prdata;
  assign pready  = s.pready;
  assign pslverr = s.pslverr;
  assign hsAck   = s.hsAck;
  assign hsNak   = s.hsNak;
  assign txValid = s.txValid;
  assign txData  = s.txData;
  assign txDone  = s.txDone;
  assign irq     = s.irq;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_setup_end;
    rxEnd && s.rxBusy && s.setup_received_flag && !s.rxDrop;
  endsequence
  sequence s_out_end;
    rxEnd && s.rxBusy && !s.setup_received_flag && !s.rxDrop;
  endsequence

  property p_setup_ack;
    s_setup_end |=> hsAck && s.setupRcv;
  endproperty
  a_setup_ack: assert property (p_setup_ack)
    else $error("setup not acked or flag not set");

  // a mask write may drop the line legally, so it is left out here
  property p_setup_irq;
    s.setupRcv && s.ien[2] && !wrCsr && !wrIen |=> irq;
  endproperty
  a_setup_irq: assert property (p_setup_irq)
    else $error("setup interrupt not pending");

  property p_dual_setup;
    tokSetup && s.dual && !s.rxBusy && !tokOut |=> !s.rxBusy;
  endproperty
  a_dual_setup: assert property (p_dual_setup)
    else $error("setup taken on ping-pong endpoint");

  property p_tx_comp;
    hostAck && s.waitAck && !s.sending && !tokIn |=> s.tx_complete_flag;
  endproperty
  a_tx_comp: assert property (p_tx_comp)
    else $error("tx complete not set on host ack");

  property p_in_nak;
    tokIn && !s.sending && !s.txRdy[s.usbBank] |=> hsNak && !txValid;
  endproperty
  a_in_nak: assert property (p_in_nak)
    else $error("IN without ready bank not naked");

  property p_out_nak;
    rxEnd && s.rxBusy && s.rxDrop |=> hsNak && !hsAck;
  endproperty
  a_out_nak: assert property (p_out_nak)
    else $error("OUT while fifo owned not naked");

  property p_out_full;
    s_out_end |=> hsAck && s.rxFull;
  endproperty
  a_out_full: assert property (p_out_full)
    else $error("rx full flag not set after store");

  property p_hold_bank;
    s.rxFull && !wrCsr && !tokSetup |=> $stable(s.rxCnt);
  endproperty
  a_hold_bank: assert property (p_hold_bank)
    else $error("full bank overwritten");

  property p_irq_off;
    !(|({s.setupRcv, s.rxFull, s.tx_complete_flag} & s.ien)) && !rxEnd && !hostAck
      && !wrIen |=> !irq;
  endproperty
  a_irq_off: assert property (p_irq_off)
    else $error("interrupt stays after flags cleared");
endmodule : ueth_endpoint

// [ueth_host_model.sv]
// Purpose: behavioural USB host on the serial engine side
// Assumes: one token at a time, all pulses one clk wide
// Notes:   idle rxData is inverted so no stale byte lingers
`timescale 1ns/1ps
module ueth_host_model (
  input  wire logic       clk,
  input  wire logic       hsAck,
  input  wire logic       hsNak,
  input  wire logic       txValid,
  input  wire logic [7:0] txData,
  input  wire logic       txDone,
  output logic            tokSetup,
  output logic            tokOut,
  output logic            tokIn,
  output logic            rxValid,
  output logic [7:0]      rxData,
  output logic            rxEnd,
  output logic            hostAck
);
  // ==========================================
  // idle lines
  initial begin
    {tokSetup, tokOut, tokIn, rxValid, rxEnd, hostAck} = '0;
    rxData = 8'h5a;
  end
  // token, bytes, end; hs is 1 ack, 2 nak, 0 none
  task send_pkt(input logic st, input logic [63:0] p, input int n,
                output int hs);
    int i;
    @(posedge clk);
    tokSetup <= st;
    tokOut <= !st;
    @(posedge clk);
    {tokSetup, tokOut} <= 2'b00;
    for (i = 0; i < n; i++) begin
      rxValid <= 1'b1;
      rxData <= p[8*i+:8];
      @(posedge clk);
    end
    rxValid <= 1'b0;
    rxData <= ~rxData;  // no stale byte after the packet
    rxEnd <= 1'b1;
    @(posedge clk);
    rxEnd <= 1'b0;
    hs = 0;
    for (i = 0; i < 4 && hs == 0; i++) begin
      @(posedge clk);
      hs = hsAck ? 1 : (hsNak ? 2 : 0);
    end
  endtask : send_pkt
  // in token, collect bytes, ack only when asked
  task get_in(input logic ack, output int hs, output logic [63:0] d,
              output int n);
    int i;
    @(posedge clk);
    tokIn <= 1'b1;
    @(posedge clk);
    tokIn <= 1'b0;
    hs = 0;
    n = 0;
    d = '0;
    for (i = 0; i < 80 && hs == 0; i++) begin
      @(posedge clk);
      if (hsNak) hs = 2;
      else if (txDone) hs = 1;
      else if (txValid) begin
        d[8*n+:8] = txData;
        n++;
      end
    end
    if (hs == 1 && ack) begin
      hostAck <= 1'b1;
      @(posedge clk);
      hostAck <= 1'b0;
    end
  endtask : get_in
endmodule : ueth_host_model

// [test_usb_endpoint_transaction_handler.sv]
// Purpose: self-checking bench of the endpoint transaction handler
// Assumes: APB master tasks here, host model on the serial side
// Notes:   expected rx bytes live in a queue model of the fifo
`timescale 1ns/1ps
module test_usb_endpoint_transaction_handler;
  logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, err, pready, pslverr, irq;
  logic        hsAck, hsNak, txValid, txDone, tokSetup, tokOut, tokIn;
  logic        rxValid, rxEnd, hostAck;
  logic [7:0]  rxData, txData, fifoQ[$];
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rdat, seed = 32'h0001_158e;
  logic [63:0] pkt, keep, got;
  int          mismatches = 0, samples_checked = 0, hs, n, i;
  localparam logic [11:0] CSR = ueth_pkg::OFF_CSR;
  localparam logic [11:0] FDR = ueth_pkg::OFF_FDR;
  localparam logic [11:0] IEN = ueth_pkg::OFF_IEN;
  always #5 clk = ~clk;
  // ==========================================
  // design and host
  ueth_endpoint u_dut (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tokSetup(tokSetup), .tokOut(tokOut), .tokIn(tokIn),
    .rxValid(rxValid), .rxData(rxData), .rxEnd(rxEnd),
    .hostAck(hostAck), .hsAck(hsAck), .hsNak(hsNak), .txValid(txValid),
    .txData(txData), .txDone(txDone), .irq(irq));
  ueth_host_model u_host (.clk(clk), .hsAck(hsAck), .hsNak(hsNak),
    .txValid(txValid), .txData(txData), .txDone(txDone),
    .tokSetup(tokSetup), .tokOut(tokOut), .tokIn(tokIn),
    .rxValid(rxValid), .rxData(rxData), .rxEnd(rxEnd), .hostAck(hostAck));
  // ==========================================
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // expected control word; count is what the queue still holds
  function automatic logic [31:0] csrv(input logic [2:0] f,
                                       input logic t, input logic d);
    return {9'h000, 7'(fifoQ.size()), 8'h00, d, 2'b00, t, 1'b0, f};
  endfunction : csrv
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk_reg
  task automatic chk_pin(input logic g, input logic e);
    repeat (3) @(posedge clk);  // level output lags its cause by one
    chk_reg({31'h0, g === 1'bx ? 1'bx : irq}, {31'h0, e});
  endtask : chk_pin
  // one transfer; held until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] wd);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      mismatches++;
      give_verdict;
    end else begin
      rdat = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk_reg(rdat, e);
  endtask : rd
  task automatic fill(input int m, input logic rx);
    for (int j = 0; j < m; j++) begin
      seed = lfsr(seed);
      pkt[8*j+:8] = seed[7:0];
      if (rx) fifoQ.push_back(seed[7:0]);
    end
  endtask : fill
  task automatic load(input int m);
    for (int j = 0; j < m; j++) apb(1'b1, FDR, {24'h0, pkt[8*j+:8]});
  endtask : load
  task automatic drain;
    while (fifoQ.size() > 0) rd(FDR, {24'h0, fifoQ.pop_front()});
  endtask : drain
  // ==========================================
  // scenarios
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd(CSR, 32'h0000_0000);
    rd(IEN, 32'h0000_0000);
    rd(12'h00c, 32'h0000_0000);
    chk_reg({31'h0, err}, 32'h0000_0001);
    apb(1'b1, IEN, 32'h0000_0007);
    fill(8, 1'b1);
    u_host.send_pkt(1'b1, pkt, 8, hs);
    chk_reg(32'(hs), 32'd1);
    rd(CSR, csrv(3'b100, 1'b0, 1'b0));
    chk_pin(1'b0, 1'b1);
    u_host.send_pkt(1'b0, pkt, 2, hs);
    chk_reg(32'(hs), 32'd2);
    drain;
    rd(CSR, csrv(3'b100, 1'b0, 1'b0));
    apb(1'b1, IEN, 32'h0000_0000);
    chk_pin(1'b0, 1'b0);
    apb(1'b1, IEN, 32'h0000_0007);
    apb(1'b1, CSR, 32'h0000_0004);
    chk_pin(1'b0, 1'b0);
    fill(3, 1'b1);
    u_host.send_pkt(1'b0, pkt, 3, hs);
    chk_reg(32'(hs), 32'd1);
    rd(CSR, csrv(3'b010, 1'b0, 1'b0));
    chk_pin(1'b0, 1'b1);
    u_host.send_pkt(1'b0, pkt, 2, hs);
    chk_reg(32'(hs), 32'd2);
    drain;
    apb(1'b1, CSR, 32'h0000_0002);
    chk_pin(1'b0, 1'b0);
    u_host.send_pkt(1'b0, pkt, 0, hs);
    chk_reg(32'(hs), 32'd1);
    apb(1'b1, CSR, 32'h0000_0002);
    u_host.get_in(1'b1, hs, got, n);
    chk_reg(32'(hs), 32'd2);
    fill(2, 1'b0);
    load(2);
    apb(1'b1, CSR, 32'h0000_0010);
    rd(CSR, csrv(3'b000, 1'b1, 1'b0));
    u_host.get_in(1'b1, hs, got, n);
    chk_reg({got[31:0]}, {16'h0, pkt[15:0]});
    rd(CSR, csrv(3'b001, 1'b0, 1'b0));
    chk_pin(1'b0, 1'b1);
    apb(1'b1, CSR, 32'h0000_0011);
    u_host.get_in(1'b1, hs, got, n);
    chk_reg(32'(n), 32'd0);
    apb(1'b1, CSR, 32'h0000_0081);
    fill(2, 1'b0);
    keep = pkt;
    load(2);
    apb(1'b1, CSR, 32'h0000_0090);
    fill(1, 1'b0);
    load(1);
    u_host.get_in(1'b1, hs, got, n);
    chk_reg(got[31:0], {16'h0, keep[15:0]});
    apb(1'b1, CSR, 32'h0000_0091);
    u_host.get_in(1'b1, hs, got, n);
    chk_reg(got[31:0], {24'h0, pkt[7:0]});
    apb(1'b1, CSR, 32'h0000_0081);
    u_host.get_in(1'b0, hs, got, n);
    chk_reg(32'(hs), 32'd2);
    u_host.send_pkt(1'b1, pkt, 2, hs);
    chk_reg(32'(hs), 32'd0);
    rd(CSR, csrv(3'b000, 1'b0, 1'b1));
    give_verdict;
  end
  // hang guard
  initial begin
    #200_000;
    mismatches++;
    give_verdict;
  end
endmodule : test_usb_endpoint_transaction_handler
